/* File: rtl/timer16_edge_sync.v */
// Three-stage pin synchroniser with agreement check and edge pulses
`timescale 1ns/1ps
module timer16_edge_sync (
   input  wire clk,
   input  wire srst,
   input  wire pin,
   output reg  level_q,
   output reg  rise_q,
   output reg  fall_q
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   // ------------------------------------------------------------
   // Synchroniser; a change counts when stages two and three agree
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         s1_q    <= 1'b0;
         s2_q    <= 1'b0;
         s3_q    <= 1'b0;
         level_q <= 1'b0;
         rise_q  <= 1'b0;
         fall_q  <= 1'b0;
      end else begin
         s1_q   <= pin;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
            rise_q  <= s3_q & ~level_q;
            fall_q  <= ~s3_q & level_q;
         end
      end
   end
endmodule // timer16_edge_sync

/* File: rtl/timer16_map.vh */
// Register offsets, field positions and encodings of the 16-bit timer
// Contract
// RULE1: Select 000 stops; 001,/8,/64,/256,/1024 taps
// RULE2: Select 110/111 counts external pin edges
// RULE3: Force strobes only act in non-PWM modes
// RULE4: Force strobe is immediate match using mode bits
// RULE5: Forced match: no interrupt, no clear
// RULE6: Force bits always read back zero
// RULE7: Low byte at offset, high at plus one
// RULE8: One shared high-byte latch for 16-bit access
// RULE9: Counter write blocks next timer-clock match
// RULE10: Software avoids changing a running counter
// RULE11: Capture event copies counter into capture register
// RULE12: Capture register may serve as top value
// RULE13: Compare registers continuously matched against counter
// RULE14: Mask bit 5 enables capture interrupt
// RULE15: Mask bit 2 enables compare-B interrupt
// RULE16: Mask bit 1 enables compare-A interrupt
// RULE17: Mask bit 0 enables overflow interrupt
// RULE18: Select field bits 2:0 of reg B, 0x81
// RULE19: Capture pin disabled when capture is top
// RULE20: Low read latches high; high write first
`ifndef TIMER16_MAP_VH
`define TIMER16_MAP_VH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define OFS_IRQ_MASK   8'h6f
`define OFS_FLAGS      8'h36
`define OFS_CTRL_A     8'h80
`define OFS_CTRL_B     8'h81
`define OFS_FORCE      8'h82
`define OFS_COUNT      8'h84
`define OFS_CAPTURE    8'h86
`define OFS_CMP_A      8'h88
`define OFS_CMP_B      8'h8a
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_CAPTURE    5
`define BIT_MATCH_B    2
`define BIT_MATCH_A    1
`define BIT_OVERFLOW   0
`define BIT_FORCE_A    7
`define BIT_FORCE_B    6
`define BIT_NOISE      7
`define BIT_EDGE       6
`define BIT_WGM_HI     3
`define IRQ_MASK_BITS  8'h27
`define CTRL_B_BITS    8'hdf
`define CTRL_A_BITS    8'hf3
// ------------------------------------------------------------
// Clock select codes and divider taps
// ------------------------------------------------------------
`define CS_STOP        3'h0
`define CS_DIV1        3'h1
`define CS_DIV8        3'h2
`define CS_DIV64       3'h3
`define CS_DIV256      3'h4
`define CS_DIV1024     3'h5
`define CS_EXT_FALL    3'h6
`define CS_EXT_RISE    3'h7
`define PRE_W          10
`define TAP8           10'h007
`define TAP64          10'h03f
`define TAP256         10'h0ff
`define TAP1024        10'h3ff
// ------------------------------------------------------------
// Waveform mode codes and fixed tops
// ------------------------------------------------------------
`define WGM_NORMAL     4'h0
`define WGM_CLR_A      4'h4
`define WGM_PFC_ICR    4'h8
`define WGM_PC_ICR     4'ha
`define WGM_CLR_ICR    4'hc
`define WGM_FAST_ICR   4'he
`define TOP_MAX        16'hffff
`define TOP_8BIT       16'h00ff
`define TOP_9BIT       16'h01ff
`define TOP_10BIT      16'h03ff
`define NOISE_SAMPLES  4
`endif

/* File: rtl/timer16_regs_clock_select.v */
// 16-bit timer register block with clock select, capture and compare
`timescale 1ns/1ps
`include "timer16_map.vh"
module timer16_regs_clock_select (
   input  wire       clk,
   input  wire       srst,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire       global_irq_en,
   input  wire       cmp_event,
   input  wire       capture_pin,
   input  wire       ext_clock_pin,
   input  wire       prescaler_reset,
   input  wire [3:0] irq_ack,
   output reg  [7:0] reg_rdata,
   output reg        wave_out_a,
   output reg        wave_out_b,
   output reg        wave_en_a,
   output reg        wave_en_b,
   output reg        irq_capture,
   output reg        irq_match_b,
   output reg        irq_match_a,
   output reg        irq_overflow
);
   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   reg  [7:0]         irq_mask_q;
   reg  [7:0]         control_reg_a_q;
   reg  [7:0]         control_reg_b_q;
   reg  [7:0]         flags_q;
   reg  [15:0]        counter_value_q;
   reg  [15:0]        capture_value_q;
   reg  [15:0]        compare_a_value_q;
   reg  [15:0]        compare_b_value_q;
   reg  [7:0]         high_latch_q;
   reg  [`PRE_W-1:0]  prescale_q;
   reg                block_match_q;
   reg                count_up_q;
   reg  [`NOISE_SAMPLES-1:0] noise_q;
   reg                cap_level_q;
   reg                cap_filt_q;
   wire               ext_level;
   wire               ext_rise;
   wire               ext_fall;
   wire               cap_level;
   wire               cap_rise;
   wire               cap_fall;
   wire [2:0]         clock_sel;
   wire [3:0]         waveform_mode;
   wire [1:0]         compare_output_mode_a;
   wire [1:0]         compare_output_mode_b;
   reg                tick;
   reg  [15:0]        top_value;
   reg                pwm_mode;
   reg                dual_slope;
   wire               icr_is_top;
   wire               match_a;
   wire               match_b;
   wire               write_count;
   wire               force_match_a;
   wire               force_match_b;
   reg                cap_src;
   reg                cap_edge;

   assign clock_sel             = control_reg_b_q[2:0];                 // RULE18
   assign waveform_mode         = {control_reg_b_q[4:3], control_reg_a_q[1:0]};
   assign compare_output_mode_a = control_reg_a_q[7:6];
   assign compare_output_mode_b = control_reg_a_q[5:4];
   assign write_count           = reg_wr & (reg_addr == `OFS_COUNT);
   assign force_match_a = reg_wr & (reg_addr == `OFS_FORCE) & reg_wdata[`BIT_FORCE_A] & ~pwm_mode; // RULE3
   assign force_match_b = reg_wr & (reg_addr == `OFS_FORCE) & reg_wdata[`BIT_FORCE_B] & ~pwm_mode; // RULE3

   // ------------------------------------------------------------
   // Pin synchronisers for the external clock and capture inputs
   // ------------------------------------------------------------
   timer16_edge_sync u_ext_sync (
      .clk     (clk),
      .srst    (srst),
      .pin     (ext_clock_pin),
      .level_q (ext_level),
      .rise_q  (ext_rise),
      .fall_q  (ext_fall)
   );

   timer16_edge_sync u_cap_sync (
      .clk     (clk),
      .srst    (srst),
      .pin     (capture_pin),
      .level_q (cap_level),
      .rise_q  (cap_rise),
      .fall_q  (cap_fall)
   );

   // ------------------------------------------------------------
   // Free-running prescaler, cleared by the shared reset request
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (srst || prescaler_reset) begin
         prescale_q <= {`PRE_W{1'b0}};
      end else begin
         prescale_q <= prescale_q + 1'b1;
      end
   end

   // Clock select decode into one timer tick enable
   always @* begin
      case (clock_sel)
         `CS_STOP:     tick = 1'b0;                                          // RULE1
         `CS_DIV1:     tick = 1'b1;                                          // RULE1
         `CS_DIV8:     tick = ((prescale_q & `TAP8) == `TAP8);               // RULE1
         `CS_DIV64:    tick = ((prescale_q & `TAP64) == `TAP64);             // RULE1
         `CS_DIV256:   tick = ((prescale_q & `TAP256) == `TAP256);           // RULE1
         `CS_DIV1024:  tick = (prescale_q == `TAP1024);                      // RULE1
         `CS_EXT_FALL: tick = ext_fall;                                      // RULE2
         `CS_EXT_RISE: tick = ext_rise;                                      // RULE2
         default:      tick = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // Waveform mode decode: top source, PWM and slope
   // ------------------------------------------------------------
   always @* begin
      top_value  = `TOP_MAX;
      pwm_mode   = 1'b1;
      dual_slope = 1'b0;
      case (waveform_mode)
         4'h0: pwm_mode = 1'b0;
         4'h1: begin top_value = `TOP_8BIT;  dual_slope = 1'b1; end
         4'h2: begin top_value = `TOP_9BIT;  dual_slope = 1'b1; end
         4'h3: begin top_value = `TOP_10BIT; dual_slope = 1'b1; end
         4'h4: begin top_value = compare_a_value_q; pwm_mode = 1'b0; end
         4'h5: top_value = `TOP_8BIT;
         4'h6: top_value = `TOP_9BIT;
         4'h7: top_value = `TOP_10BIT;
         4'h8: begin top_value = capture_value_q;   dual_slope = 1'b1; end // RULE12
         4'h9: begin top_value = compare_a_value_q; dual_slope = 1'b1; end
         4'ha: begin top_value = capture_value_q;   dual_slope = 1'b1; end // RULE12
         4'hb: begin top_value = compare_a_value_q; dual_slope = 1'b1; end
         4'hc: begin top_value = capture_value_q;   pwm_mode = 1'b0; end  // RULE12
         4'he: top_value = capture_value_q;                               // RULE12
         4'hf: top_value = compare_a_value_q;
         default: pwm_mode = 1'b0;
      endcase
   end

   assign icr_is_top = (waveform_mode == `WGM_PFC_ICR) | (waveform_mode == `WGM_PC_ICR) |
                       (waveform_mode == `WGM_CLR_ICR) | (waveform_mode == `WGM_FAST_ICR);

   // Continuous comparators, masked on the tick after a counter write
   assign match_a = tick & ~block_match_q & (counter_value_q == compare_a_value_q); // RULE13 RULE9
   assign match_b = tick & ~block_match_q & (counter_value_q == compare_b_value_q); // RULE13 RULE9

   // ------------------------------------------------------------
   // Capture source with optional four-sample noise filter
   // ------------------------------------------------------------
   always @* begin
      cap_src  = cmp_event;
      cap_edge = 1'b0;
      if (!control_reg_b_q[`BIT_NOISE]) begin
         cap_edge = control_reg_b_q[`BIT_EDGE] ? cap_rise : cap_fall;
      end else begin
         cap_edge = control_reg_b_q[`BIT_EDGE] ? (cap_filt_q & ~cap_level_q) : (~cap_filt_q & cap_level_q);
      end
   end

   // Filter output moves only after four equal samples
   always @(posedge clk) begin
      if (srst) begin
         noise_q     <= {`NOISE_SAMPLES{1'b0}};
         cap_filt_q  <= 1'b0;
         cap_level_q <= 1'b0;
      end else begin
         noise_q     <= {noise_q[`NOISE_SAMPLES-2:0], cap_level};
         cap_level_q <= cap_filt_q;
         if (&noise_q || ~|noise_q) begin
            cap_filt_q <= noise_q[0];
         end
      end
   end

   // ------------------------------------------------------------
   // Counter, capture, flags and byte-pair register access
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         irq_mask_q        <= 8'h00;
         control_reg_a_q   <= 8'h00;
         control_reg_b_q   <= 8'h00;
         flags_q           <= 8'h00;
         counter_value_q   <= 16'h0000;
         capture_value_q   <= 16'h0000;
         compare_a_value_q <= 16'h0000;
         compare_b_value_q <= 16'h0000;
         high_latch_q      <= 8'h00;
         block_match_q     <= 1'b0;
         count_up_q        <= 1'b1;
      end else begin
         // Block stays armed until the next timer tick has passed
         if (write_count) begin
            block_match_q <= 1'b1;                                         // RULE9
         end else if (tick) begin
            block_match_q <= 1'b0;
         end
         // Counting; a forced match never clears the counter
         if (tick && !write_count) begin                                  // RULE5
            if (dual_slope) begin
               if (count_up_q && counter_value_q >= top_value) begin
                  count_up_q      <= 1'b0;
                  counter_value_q <= counter_value_q - 16'h0001;
               end else if (!count_up_q && counter_value_q == 16'h0000) begin
                  count_up_q      <= 1'b1;
                  counter_value_q <= 16'h0001;
               end else begin
                  counter_value_q <= count_up_q ? counter_value_q + 16'h0001 : counter_value_q - 16'h0001;
               end
            end else if (counter_value_q == top_value && waveform_mode != `WGM_NORMAL) begin
               counter_value_q <= 16'h0000;
            end else begin
               counter_value_q <= counter_value_q + 16'h0001;
            end
         end
         // Capture takes the counter unless the capture register is top
         if ((cap_edge || cap_src) && !icr_is_top) begin                 // RULE19
            capture_value_q <= counter_value_q;                           // RULE11
         end
         // Flags: hardware set wins over software clear; forced match sets none
         flags_q[`BIT_CAPTURE]  <= ((cap_edge || cap_src) && !icr_is_top) |
                                   (icr_is_top & tick & (counter_value_q == top_value)) |
                                   (flags_q[`BIT_CAPTURE] & ~irq_ack[3] &
                                    ~(reg_wr & (reg_addr == `OFS_FLAGS) & reg_wdata[`BIT_CAPTURE]));
         flags_q[`BIT_MATCH_B]  <= match_b | (flags_q[`BIT_MATCH_B] & ~irq_ack[2] &
                                   ~(reg_wr & (reg_addr == `OFS_FLAGS) & reg_wdata[`BIT_MATCH_B])); // RULE5
         flags_q[`BIT_MATCH_A]  <= match_a | (flags_q[`BIT_MATCH_A] & ~irq_ack[1] &
                                   ~(reg_wr & (reg_addr == `OFS_FLAGS) & reg_wdata[`BIT_MATCH_A])); // RULE5
         flags_q[`BIT_OVERFLOW] <= (tick & ~dual_slope & (counter_value_q == `TOP_MAX)) |
                                   (tick & dual_slope & ~count_up_q & (counter_value_q == 16'h0001)) |
                                   (flags_q[`BIT_OVERFLOW] & ~irq_ack[0] &
                                    ~(reg_wr & (reg_addr == `OFS_FLAGS) & reg_wdata[`BIT_OVERFLOW]));
         // Byte registers and the shared high-byte latch
         if (reg_wr) begin
            case (reg_addr)
               `OFS_IRQ_MASK: irq_mask_q      <= reg_wdata & `IRQ_MASK_BITS;
               `OFS_CTRL_A:   control_reg_a_q <= reg_wdata & `CTRL_A_BITS;
               `OFS_CTRL_B:   control_reg_b_q <= reg_wdata & `CTRL_B_BITS;  // RULE18
               `OFS_COUNT:    counter_value_q <= {high_latch_q, reg_wdata}; // RULE20 RULE8
               `OFS_CAPTURE:  capture_value_q <= {high_latch_q, reg_wdata}; // RULE20 RULE8
               `OFS_CMP_A:    compare_a_value_q <= {high_latch_q, reg_wdata}; // RULE20 RULE8
               `OFS_CMP_B:    compare_b_value_q <= {high_latch_q, reg_wdata}; // RULE20 RULE8
               `OFS_COUNT + 8'h01, `OFS_CAPTURE + 8'h01,
               `OFS_CMP_A + 8'h01, `OFS_CMP_B + 8'h01:
                              high_latch_q <= reg_wdata;                  // RULE7 RULE8
               default: ;
            endcase
         end else if (reg_rd) begin
            // Reading a low byte freezes its high byte for the next read
            case (reg_addr)
               `OFS_COUNT:   high_latch_q <= counter_value_q[15:8];      // RULE20
               `OFS_CAPTURE: high_latch_q <= capture_value_q[15:8];      // RULE20
               `OFS_CMP_A:   high_latch_q <= compare_a_value_q[15:8];    // RULE20
               `OFS_CMP_B:   high_latch_q <= compare_b_value_q[15:8];    // RULE20
               default: ;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Read data register; high bytes come from the shared latch
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `OFS_IRQ_MASK:          reg_rdata <= irq_mask_q;
            `OFS_FLAGS:             reg_rdata <= flags_q;
            `OFS_CTRL_A:            reg_rdata <= control_reg_a_q;
            `OFS_CTRL_B:            reg_rdata <= control_reg_b_q;
            `OFS_FORCE:             reg_rdata <= 8'h00;                  // RULE6
            `OFS_COUNT:             reg_rdata <= counter_value_q[7:0];   // RULE7
            `OFS_CAPTURE:           reg_rdata <= capture_value_q[7:0];   // RULE7
            `OFS_CMP_A:             reg_rdata <= compare_a_value_q[7:0]; // RULE7
            `OFS_CMP_B:             reg_rdata <= compare_b_value_q[7:0]; // RULE7
            `OFS_COUNT + 8'h01,
            `OFS_CAPTURE + 8'h01,
            `OFS_CMP_A + 8'h01,
            `OFS_CMP_B + 8'h01:     reg_rdata <= high_latch_q;           // RULE8
            default:                reg_rdata <= 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Interrupt requests: flag, mask bit and global enable
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         irq_capture  <= 1'b0;
         irq_match_b  <= 1'b0;
         irq_match_a  <= 1'b0;
         irq_overflow <= 1'b0;
      end else begin
         irq_capture  <= global_irq_en & irq_mask_q[`BIT_CAPTURE]  & flags_q[`BIT_CAPTURE];  // RULE14
         irq_match_b  <= global_irq_en & irq_mask_q[`BIT_MATCH_B]  & flags_q[`BIT_MATCH_B];  // RULE15
         irq_match_a  <= global_irq_en & irq_mask_q[`BIT_MATCH_A]  & flags_q[`BIT_MATCH_A];  // RULE16
         irq_overflow <= global_irq_en & irq_mask_q[`BIT_OVERFLOW] & flags_q[`BIT_OVERFLOW]; // RULE17
      end
   end

   // ------------------------------------------------------------
   // Waveform outputs; forced or real match acts on the mode bits now
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         wave_out_a <= 1'b0;
         wave_out_b <= 1'b0;
         wave_en_a  <= 1'b0;
         wave_en_b  <= 1'b0;
      end else begin
         wave_en_a <= |compare_output_mode_a;
         wave_en_b <= |compare_output_mode_b;
         if (match_a || force_match_a) begin                              // RULE4
            case (compare_output_mode_a)
               2'h1:    wave_out_a <= ~wave_out_a;
               2'h2:    wave_out_a <= dual_slope ? ~count_up_q : 1'b0;
               2'h3:    wave_out_a <= dual_slope ? count_up_q : 1'b1;
               default: wave_out_a <= wave_out_a;
            endcase
         end
         if (match_b || force_match_b) begin                              // RULE4
            case (compare_output_mode_b)
               2'h1:    wave_out_b <= ~wave_out_b;
               2'h2:    wave_out_b <= dual_slope ? ~count_up_q : 1'b0;
               2'h3:    wave_out_b <= dual_slope ? count_up_q : 1'b1;
               default: wave_out_b <= wave_out_b;
            endcase
         end
      end
   end
endmodule // timer16_regs_clock_select

/* File: sim/tb_top.sv */
// Self-checking bench for the 16-bit timer register block
`timescale 1ns/1ps
`include "timer16_map.vh"
module tb_top;
   reg clk, srst, reg_wr, reg_rd, global_irq_en, cmp_event, capture_pin, ext_clock_pin, prescaler_reset;
   reg  [7:0] reg_addr, reg_wdata;
   reg  [3:0] irq_ack;
   wire [7:0] reg_rdata;
   wire       wave_out_a, wave_out_b, wave_en_a, wave_en_b, irq_capture, irq_match_b, irq_match_a, irq_overflow;
   reg [15:0] v;
   integer    bad_count, n_tests, i;
   timer16_regs_clock_select uut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .global_irq_en(global_irq_en), .cmp_event(cmp_event),
      .capture_pin(capture_pin), .ext_clock_pin(ext_clock_pin), .prescaler_reset(prescaler_reset),
      .irq_ack(irq_ack), .reg_rdata(reg_rdata), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
      .wave_en_a(wave_en_a), .wave_en_b(wave_en_b), .irq_capture(irq_capture), .irq_match_b(irq_match_b),
      .irq_match_a(irq_match_a), .irq_overflow(irq_overflow));
   // ------------------------------------------------------------
   // Clock, bus tasks and comparison
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task chk(input [15:0] seen, input [15:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // One strobe cycle per byte; strobe drops at the next edge
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input [7:0] a, output [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk) d = reg_rdata;
   endtask
   // High first on write, low first on read, so the latch pairs them
   task wr16(input [7:0] a, input [15:0] d);
      wr(a + 8'h01, d[15:8]);
      wr(a, d[7:0]);
   endtask
   task rd16(input [7:0] a, output [15:0] d);
      rd(a, d[7:0]);
      rd(a + 8'h01, d[15:8]);
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk);
   endtask
   // Each level spans several synchroniser samples
   task pulse3;
      repeat (3) begin
         @(posedge clk);
         ext_clock_pin <= 1'b1;
         tick(4);
         ext_clock_pin <= 1'b0;
         tick(4);
      end
      tick(8);
   endtask
   task report_and_stop;
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      {srst, reg_wr, reg_rd, global_irq_en, cmp_event, capture_pin, ext_clock_pin, prescaler_reset} = 8'h80;
      {reg_addr, reg_wdata, irq_ack, bad_count, n_tests, v} = 0;
      tick(6);
      srst <= 1'b0;
      rd16(`OFS_COUNT, v); chk(v, 16'h0000);
      rd(`OFS_IRQ_MASK, v[7:0]); chk(v[7:0], 8'h00);
      $display("Test reset values done");
      wr16(`OFS_CMP_A, 16'h1234);
      wr16(`OFS_CMP_B, 16'h5678);
      rd16(`OFS_CMP_A, v); chk(v, 16'h1234);
      rd16(`OFS_CMP_B, v); chk(v, 16'h5678);
      wr(`OFS_IRQ_MASK, 8'hff);
      rd(`OFS_IRQ_MASK, v[7:0]); chk(v[7:0], `IRQ_MASK_BITS);
      rd(8'h00, v[7:0]); chk(v[7:0], 8'h00);
      wr(`OFS_CTRL_B, 8'h3f);
      rd(`OFS_CTRL_B, v[7:0]); chk(v[7:0], 8'h1f);
      $display("Test byte pairs done");
      // Stopped counter must hold, and a rising pin edge captures it
      wr16(`OFS_COUNT, 16'h0321);
      wr(`OFS_CTRL_B, 8'h40);
      tick(20);
      capture_pin <= 1'b1;
      tick(12);
      rd16(`OFS_COUNT, v); chk(v, 16'h0321);
      rd16(`OFS_CAPTURE, v); chk(v, 16'h0321);
      chk(irq_capture, 1'b0);
      global_irq_en <= 1'b1;
      tick(3);
      chk(irq_capture, 1'b1);
      irq_ack <= 4'h8;
      tick(1);
      irq_ack <= 4'h0;
      tick(3);
      chk(irq_capture, 1'b0);
      $display("Test capture done");
      wr16(`OFS_COUNT, 16'h0000);
      wr(`OFS_CTRL_B, 8'h07);
      pulse3;
      wr(`OFS_CTRL_B, 8'h06);
      pulse3;
      wr(`OFS_CTRL_B, 8'h00);
      rd16(`OFS_COUNT, v); chk(v, 16'h0006);
      $display("Test external clock done");
      // Prescaler phase is free running, so allow one count either way
      wr16(`OFS_COUNT, 16'h0000);
      wr(`OFS_CTRL_B, 8'h02);
      tick(80);
      wr(`OFS_CTRL_B, 8'h00);
      rd16(`OFS_COUNT, v); chk(v >= 16'h9 && v <= 16'hb, 1'b1);
      wr16(`OFS_CMP_B, 16'h0010);
      wr16(`OFS_COUNT, 16'h0000);
      wr(`OFS_CTRL_B, 8'h01);
      for (i = 0; i < 40 && irq_match_b !== 1'b1; i = i + 1) tick(1);
      chk(irq_match_b, 1'b1);
      wr(`OFS_CTRL_B, 8'h00);
      irq_ack <= 4'h4;
      tick(1);
      irq_ack <= 4'h0;
      tick(3);
      chk(irq_match_b, 1'b0);
      $display("Test prescaler and match done");
      wr(`OFS_CTRL_A, 8'h50);
      wr(`OFS_FORCE, 8'hc0);
      tick(3);
      chk({wave_en_a, wave_en_b, wave_out_a, wave_out_b}, 4'hf);
      wr(`OFS_CTRL_A, 8'ha1);
      wr(`OFS_FORCE, 8'hc0);
      tick(3);
      chk({wave_out_a, wave_out_b}, 2'b11);
      wr(`OFS_CTRL_A, 8'ha0);
      wr(`OFS_FORCE, 8'hc0);
      tick(3);
      chk({wave_out_a, wave_out_b, irq_match_a, irq_match_b, irq_overflow}, 5'h0);
      wr(`OFS_IRQ_MASK, 8'h00);
      rd(`OFS_FORCE, v[7:0]); chk(v[7:0], 8'h00);
      $display("Test forced match done");
      report_and_stop;
   end
   // Tests need well under a thousand cycles
   initial begin
      tick(5000);
      bad_count = bad_count + 1;
      report_and_stop;
   end
endmodule // tb_top

/* File: sim/timer16_assertions.sv */
// Port-level checker for the 16-bit timer register block
`timescale 1ns/1ps
`include "timer16_map.vh"
module timer16_assertions (
   input logic       clk,
   input logic       srst,
   input logic [7:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic       reg_wr,
   input logic       reg_rd,
   input logic       global_irq_en,
   input logic [7:0] reg_rdata,
   input logic       wave_out_a,
   input logic       wave_out_b,
   input logic       irq_capture,
   input logic       irq_match_b,
   input logic       irq_match_a,
   input logic       irq_overflow
);
   // ------------------------------------------------------------
   // Helpers and clocking
   // ------------------------------------------------------------
   wire       rd_only = reg_rd && !reg_wr;
   wire [3:0] irqs    = {irq_capture, irq_match_b, irq_match_a, irq_overflow};
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Interrupt outputs are gated by the global enable one cycle earlier
   a_irq_global_gate: assert property (|irqs |-> $past(global_irq_en))
      else $error("interrupt raised without global enable");
   // Clearing the whole mask drops every request two edges later
   a_mask_clear_quiet: assert property (reg_wr && reg_addr == `OFS_IRQ_MASK && reg_wdata == 8'h00 |=> ##1 irqs == 4'h0)
      else $error("interrupt stayed up after mask cleared");
   a_force_reads_zero: assert property (rd_only && reg_addr == `OFS_FORCE |=> reg_rdata == 8'h00)
      else $error("force register read nonzero");
   a_mask_bits_only: assert property (rd_only && reg_addr == `OFS_IRQ_MASK |=> (reg_rdata & ~`IRQ_MASK_BITS) == 8'h00)
      else $error("undefined mask bits read as one");
   a_ctrl_b_reserved: assert property (rd_only && reg_addr == `OFS_CTRL_B |=> !reg_rdata[5])
      else $error("reserved control bit read as one");
   a_unmapped_zero: assert property (rd_only && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
      else $error("unmapped address read nonzero");
   // Read data only moves as the answer to a read strobe
   a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data changed without a read");
   a_reset_quiet: assert property ($fell(srst) |-> irqs == 4'h0 && !wave_out_a && !wave_out_b && reg_rdata == 8'h00)
      else $error("outputs not cleared by reset");
   c_irq_b: cover property (irq_match_b);
   c_capture_rd: cover property (rd_only && reg_addr == `OFS_CAPTURE);
   c_wave_a: cover property ($changed(wave_out_a));
endmodule // timer16_assertions

bind timer16_regs_clock_select timer16_assertions chk (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .global_irq_en, .reg_rdata, .wave_out_a, .wave_out_b, .irq_capture, .irq_match_b, .irq_match_a, .irq_overflow);
